/* irq_agg_pkg.sv */
// Purpose: Shared constants for the interrupt flag and enable aggregator
// Assumes: 8-bit register port, one clock, synchronous active-high reset
// Notes:   Offsets are byte addresses on the register port
`default_nettype none
package irq_agg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FLAGS_A_W = 7;
  localparam int FLAGS_B_W = 6;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_FLAGS_A = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS_B = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_ENABLES_A = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ENABLES_B = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_ERRORS = 8'h0A;

  // Reset values
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;

  // Flag register fields
  localparam int BIT_DIR_SET = 7;
  localparam int BIT_GLOBAL_REQUEST = 6;
  localparam int BIT_CARD_DETECT = 5;
  localparam int BIT_HIGH_ALERT = 6;
  localparam int BIT_LOW_ALERT = 5;
  localparam int BIT_COMMAND_END = 4;
  localparam int BIT_TRANSMIT_DONE = 3;
  localparam int BIT_RECEIVE_DONE = 2;
  localparam int BIT_FAULT = 1;
  localparam int BIT_FRAME_START = 0;

  // Enable register fields
  localparam int BIT_PIN_INVERT = 7;
  localparam int BIT_PIN_BOTH_LEVELS = 7;
  localparam int BIT_PIN_OUTPUT_ENABLE = 6;

  // Error bits that raise the fault flag
  localparam logic [DATA_W-1:0] FAULT_SOURCE_MASK = 8'h6B;
endpackage
`default_nettype wire

/* flag_bank.sv */
// Purpose: Sticky flags set by hardware, set or cleared by software write-1
// Assumes: i_write already decoded for this register
// Notes:   A hardware set in the same cycle as a software clear wins
`timescale 1ns/100ps
`default_nettype none
module flag_bank #(
  parameter int WIDTH = 6
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_write,
  input  wire logic             i_dir_set,
  input  wire logic [WIDTH-1:0] i_mask,
  input  wire logic [WIDTH-1:0] i_hw_set,
  output logic      [WIDTH-1:0] o_flags
);
  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] sw_set;
  logic [WIDTH-1:0] sw_clear;

  assign sw_set = (i_write && i_dir_set) ? i_mask : '0;
  assign sw_clear = (i_write && !i_dir_set) ? i_mask : '0;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      flags_reg <= '0;
    end
    else
    begin
      flags_reg <= (flags_reg & ~sw_clear) | sw_set | i_hw_set;
    end
  end

  assign o_flags = flags_reg;
endmodule
`default_nettype wire

/* irq_pin_driver.sv */
// Purpose: Drives the interrupt request pin from the global request
// Assumes: Pin enable low sets an open-drain pin to the invert bit: released if set, pulled low if clear
// Notes:   Output enable is active low; pin out and enable are registered
`timescale 1ns/100ps
`default_nettype none
module irq_pin_driver (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_global,
  input  wire logic i_pin_enable,
  input  wire logic i_invert,
  input  wire logic i_both_levels,
  output logic      o_pin_out,
  output logic      o_pin_oe_n
);
  logic active;
  logic level;

  assign active = i_global && i_pin_enable;
  assign level = active ^ i_invert;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pin_out  <= 1'b0;
      o_pin_oe_n <= 1'b1;
    end
    else if (i_both_levels)
    begin
      o_pin_out  <= level;
      o_pin_oe_n <= 1'b0;
    end
    else
    begin
      // Open drain: pull low only, release for high
      o_pin_out  <= 1'b0;
      o_pin_oe_n <= level;
    end
  end
endmodule
`default_nettype wire

/* irq_flag_enable_aggregator.sv */
// Purpose: Interrupt flag, enable and error registers with pin output
// Assumes: Event inputs are one-cycle pulses synchronous to i_clk
// Notes:   Read data appear in the cycle after the read strobe only
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module irq_flag_enable_aggregator (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_high_alert_event,
  input  wire logic        i_low_alert_event,
  input  wire logic        i_command_self_end,
  input  wire logic        i_command_unknown_start,
  input  wire logic        i_transmit_done_event,
  input  wire logic        i_receive_done_event,
  input  wire logic        i_frame_start_event,
  input  wire logic        i_card_detect_event,
  input  wire logic [4:0]  i_timer_underflow,
  input  wire logic [7:0]  i_error_set,
  input  wire logic [7:0]  i_error_clear,
  output logic             o_global_request,
  output logic             o_irq_pin_out,
  output logic             o_irq_pin_oe_n
);
  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  logic wr_flags_a;
  logic wr_flags_b;
  logic wr_enables_a;
  logic wr_enables_b;

  assign wr_flags_a = i_wr && hit(i_addr, irq_agg_pkg::ADDR_FLAGS_A);
  assign wr_flags_b = i_wr && hit(i_addr, irq_agg_pkg::ADDR_FLAGS_B);
  assign wr_enables_a = i_wr && hit(i_addr, irq_agg_pkg::ADDR_ENABLES_A);
  assign wr_enables_b = i_wr && hit(i_addr, irq_agg_pkg::ADDR_ENABLES_B);

  ////////////////////////////////////////////////////////////////////////////
  // Enable registers
  logic [7:0] enables_a_reg;
  logic [7:0] enables_b_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      enables_a_reg <= irq_agg_pkg::RESET_BYTE;
    end
    else if (wr_enables_a)
    begin
      enables_a_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      enables_b_reg <= irq_agg_pkg::RESET_BYTE;
    end
    else if (wr_enables_b)
    begin
      enables_b_reg <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error register, set wins over clear
  logic [7:0] error_reg;
  logic [7:0] error_next;
  logic       fault_rise;

  assign error_next = (error_reg & ~i_error_clear) | i_error_set;
  assign fault_rise = |(error_next & ~error_reg & irq_agg_pkg::FAULT_SOURCE_MASK);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      error_reg <= irq_agg_pkg::RESET_BYTE;
    end
    else
    begin
      error_reg <= error_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag banks
  logic [irq_agg_pkg::FLAGS_A_W-1:0] flags_a;
  logic [irq_agg_pkg::FLAGS_B_W-1:0] flags_b;
  logic [irq_agg_pkg::FLAGS_A_W-1:0] hw_set_a;
  logic [irq_agg_pkg::FLAGS_B_W-1:0] hw_set_b;

  always_comb
  begin
    hw_set_a = '0;
    hw_set_a[irq_agg_pkg::BIT_HIGH_ALERT] = i_high_alert_event;
    hw_set_a[irq_agg_pkg::BIT_LOW_ALERT] = i_low_alert_event;
    hw_set_a[irq_agg_pkg::BIT_COMMAND_END] = i_command_self_end || i_command_unknown_start;
    hw_set_a[irq_agg_pkg::BIT_TRANSMIT_DONE] = i_transmit_done_event;
    hw_set_a[irq_agg_pkg::BIT_RECEIVE_DONE] = i_receive_done_event;
    hw_set_a[irq_agg_pkg::BIT_FAULT] = fault_rise;
    hw_set_a[irq_agg_pkg::BIT_FRAME_START] = i_frame_start_event;
  end

  assign hw_set_b = {i_card_detect_event, i_timer_underflow};

  flag_bank #(
    .WIDTH     (irq_agg_pkg::FLAGS_A_W)
  ) u_flags_a (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_write   (wr_flags_a),
    .i_dir_set (i_wdata[irq_agg_pkg::BIT_DIR_SET]),
    .i_mask    (i_wdata[irq_agg_pkg::FLAGS_A_W-1:0]),
    .i_hw_set  (hw_set_a),
    .o_flags   (flags_a)
  );

  flag_bank #(
    .WIDTH     (irq_agg_pkg::FLAGS_B_W)
  ) u_flags_b (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_write   (wr_flags_b),
    .i_dir_set (i_wdata[irq_agg_pkg::BIT_DIR_SET]),
    .i_mask    (i_wdata[irq_agg_pkg::FLAGS_B_W-1:0]),
    .i_hw_set  (hw_set_b),
    .o_flags   (flags_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Global request
  logic any_enabled;
  logic global_reg;

  assign any_enabled = |(flags_a & enables_a_reg[irq_agg_pkg::FLAGS_A_W-1:0])
                     | |(flags_b & enables_b_reg[irq_agg_pkg::FLAGS_B_W-1:0]);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      global_reg <= 1'b0;
    end
    else
    begin
      global_reg <= any_enabled;
    end
  end

  assign o_global_request = global_reg;

  irq_pin_driver u_pin (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_global      (global_reg),
    .i_pin_enable  (enables_b_reg[irq_agg_pkg::BIT_PIN_OUTPUT_ENABLE]),
    .i_invert      (enables_a_reg[irq_agg_pkg::BIT_PIN_INVERT]),
    .i_both_levels (enables_b_reg[irq_agg_pkg::BIT_PIN_BOTH_LEVELS]),
    .o_pin_out     (o_irq_pin_out),
    .o_pin_oe_n    (o_irq_pin_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read port; direction bit reads zero
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb
  begin
    rdata_next = irq_agg_pkg::RESET_BYTE;
    if (hit(i_addr, irq_agg_pkg::ADDR_FLAGS_A))
    begin
      rdata_next[irq_agg_pkg::FLAGS_A_W-1:0] = flags_a;
    end
    else if (hit(i_addr, irq_agg_pkg::ADDR_FLAGS_B))
    begin
      rdata_next[irq_agg_pkg::BIT_GLOBAL_REQUEST] = global_reg;
      rdata_next[irq_agg_pkg::FLAGS_B_W-1:0] = flags_b;
    end
    else if (hit(i_addr, irq_agg_pkg::ADDR_ENABLES_A))
    begin
      rdata_next = enables_a_reg;
    end
    else if (hit(i_addr, irq_agg_pkg::ADDR_ENABLES_B))
    begin
      rdata_next = enables_b_reg;
    end
    else if (hit(i_addr, irq_agg_pkg::ADDR_ERRORS))
    begin
      rdata_next = error_reg;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rdata_reg <= irq_agg_pkg::RESET_BYTE;
    end
    else
    begin
      rdata_reg <= i_rd ? rdata_next : irq_agg_pkg::RESET_BYTE;
    end
  end

  assign o_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (i_rst);

  AST_SET_WRITE :
  assert property (wr_flags_b && i_wdata[7]
                   |=> (flags_b & $past(i_wdata[5:0])) == $past(i_wdata[5:0]))
  else $error("Set write to second flag bank lost a bit");

  AST_CLEAR_WRITE :
  assert property (wr_flags_b && !i_wdata[7] && hw_set_b == '0
                   |=> (flags_b & $past(i_wdata[5:0])) == '0)
  else $error("Clear write to second flag bank left a bit set");

  AST_GLOBAL_FOLLOWS :
  assert property (any_enabled |=> o_global_request)
  else $error("Global request missed an enabled flag");

  AST_GLOBAL_DROPS :
  assert property (!any_enabled |=> !o_global_request)
  else $error("Global request set with no enabled flag");

  AST_CARD_DETECT :
  assert property (i_card_detect_event
                   |=> flags_b[irq_agg_pkg::BIT_CARD_DETECT]
                   ##1 (o_global_request || !$past(enables_b_reg[irq_agg_pkg::BIT_CARD_DETECT])))
  else $error("Card detect event not held in flag");

  AST_TIMER_FLAGS :
  assert property ((|i_timer_underflow)
                   |=> (flags_b[4:0] & $past(i_timer_underflow)) == $past(i_timer_underflow))
  else $error("Timer underflow not held in flag");

  AST_PIN_INVERT :
  assert property (o_global_request && enables_b_reg[7:6] == 2'b11 && enables_a_reg[7]
                   && $stable(enables_b_reg) && $stable(enables_a_reg)
                   |=> !o_irq_pin_out && !o_irq_pin_oe_n)
  else $error("Inverted push-pull pin not low on request");

  AST_OPEN_DRAIN :
  assert property (!enables_b_reg[7] |=> !o_irq_pin_out)
  else $error("Open-drain pin driven high");

  AST_PIN_GATE :
  assert property (!enables_b_reg[irq_agg_pkg::BIT_PIN_OUTPUT_ENABLE]
                   && !enables_b_reg[irq_agg_pkg::BIT_PIN_BOTH_LEVELS]
                   |=> o_irq_pin_oe_n == $past(enables_a_reg[irq_agg_pkg::BIT_PIN_INVERT]))
  else $error("Open-drain pin left its idle level while pin output disabled");

  AST_FIRST_BANK_GATE :
  assert property ((flags_a & enables_a_reg[6:0]) != '0 |=> o_global_request)
  else $error("Enabled first-bank flag did not reach global request");

  AST_FIRST_BANK_SET :
  assert property (wr_flags_a && i_wdata[7]
                   |=> (flags_a & $past(i_wdata[6:0])) == $past(i_wdata[6:0]))
  else $error("Set write to first flag bank lost a bit");

  AST_FAULT_FLAG :
  assert property (fault_rise
                   |=> flags_a[irq_agg_pkg::BIT_FAULT]
                   && (error_reg & irq_agg_pkg::FAULT_SOURCE_MASK) != '0)
  else $error("Fault flag not set on error rise");

  AST_HOST_IDLE :
  assert property (!i_command_self_end && !i_command_unknown_start && !wr_flags_a
                   && !flags_a[4] |=> !flags_a[4])
  else $error("Command end flag set without a self end");

  AST_ERROR_READ :
  assert property (i_rd && hit(i_addr, irq_agg_pkg::ADDR_ERRORS)
                   |=> o_rdata == $past(error_reg))
  else $error("Error register read returned wrong value");

  COV_SET_CLEAR : cover property (wr_flags_b && i_wdata[7] ##1 wr_flags_b && !i_wdata[7]);
  COV_PIN_ASSERT : cover property (o_global_request ##1 !o_irq_pin_oe_n);
  COV_SET_WINS : cover property (wr_flags_b && !i_wdata[irq_agg_pkg::BIT_DIR_SET] && i_wdata[0]
                                 && i_timer_underflow[0]);
  COV_FAULT : cover property (fault_rise ##1 flags_a[1]);
endmodule
`default_nettype wire

/* irq_host_model.sv */
// Purpose: Host side of the interrupt request line
// Assumes: Line has a pull-up; released pin reads high
// Notes:   Level is what the host input buffer sees
`timescale 1ns/100ps
`default_nettype none
module irq_host_model (
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe_n,
  output logic      o_level
);
  // Resolve the wire from the active-low enable and the pull-up
  assign o_level = i_pin_oe_n ? 1'b1 : i_pin_out;
endmodule
`default_nettype wire

/* irq_flag_enable_aggregator_bench.sv */
// Purpose: Self-checking bench for the interrupt aggregator
// Assumes: Latencies as handed over: flag c1, global c2, pin c3
// Notes:   Host clears every serviced flag before the next test, except flag 0 of the second bank left set by the pin test
`timescale 1ns/100ps
`default_nettype none
module irq_flag_enable_aggregator_bench;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [8:0] ev = 9'h000;
  logic [4:0] tmr = 5'h00;
  logic [7:0] err_set = 8'h00;
  logic [7:0] err_clr = 8'h00;
  logic [7:0] o_rdata;
  logic       glob;
  logic       pin_out;
  logic       pin_oe_n;
  logic       pin_level;
  logic       lvl;
  int         error_cnt = 0;
  int         num_checks = 0;

  always #5 i_clk = ~i_clk;

  irq_flag_enable_aggregator irq_flag_enable_aggregator_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_high_alert_event(ev[6]), .i_low_alert_event(ev[5]),
    .i_command_self_end(ev[4]), .i_command_unknown_start(ev[7]),
    .i_transmit_done_event(ev[3]), .i_receive_done_event(ev[2]),
    .i_frame_start_event(ev[0]), .i_card_detect_event(ev[8]),
    .i_timer_underflow(tmr), .i_error_set(err_set), .i_error_clear(err_clr),
    .o_global_request(glob), .o_irq_pin_out(pin_out), .o_irq_pin_oe_n(pin_oe_n)
  );

  irq_host_model irq_host_model_inst (
    .i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n), .o_level(pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, "read data");
  endtask

  task automatic evt(input logic [8:0] e, input logic [4:0] t, input logic [7:0] s,
                     input logic [7:0] c);
    @(posedge i_clk);
    ev <= e;
    tmr <= t;
    err_set <= s;
    err_clr <= c;
    @(posedge i_clk);
    ev <= 9'h000;
    tmr <= 5'h00;
    err_set <= 8'h00;
    err_clr <= 8'h00;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic tend(input string name);
    $display("TEST %s finished, errors so far %0d", name, error_cnt);
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // Pin released while reset is held
    repeat (5) @(posedge i_clk);
    #1;
    chk({7'h00, pin_oe_n}, 8'h01, "pin not released in reset");
    chk({7'h00, glob}, 8'h00, "global raised in reset");
    @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset state of registers and pin
    for (int a = 6; a <= 10; a++)
      rd(8'(a), 8'h00);
    chk({7'h00, glob}, 8'h00, "global after reset");
    chk({7'h00, pin_oe_n}, 8'h00, "idle open-drain pin not pulled low");
    chk({7'h00, pin_level}, 8'h00, "pin idle level after reset");
    tend("reset");
    // Write-1 set and clear in both flag banks
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h3F);
    wr(8'h07, 8'h15);
    rd(8'h07, 8'h2A);
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h7F);
    wr(8'h06, 8'h2A);
    rd(8'h06, 8'h55);
    wr(8'h06, 8'h7F);
    wr(8'h07, 8'h3F);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    tend("write scheme");
    // Enable registers, read-only error register, unmapped address
    wr(8'h08, 8'hA5);
    rd(8'h08, 8'hA5);
    wr(8'h09, 8'h5A);
    rd(8'h09, 8'h5A);
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(8'h09, 8'h00);
    tend("registers");
    // Second bank sources, each masked then enabled
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h09, 8'h3F ^ (8'h01 << i));
      if (i == 5)
        evt(9'h100, 5'h00, 8'h00, 8'h00);
      else
        evt(9'h000, 5'(5'h01 << i), 8'h00, 8'h00);
      idle(3);
      chk({7'h00, glob}, 8'h00, "masked source raised global");
      rd(8'h07, 8'h01 << i);
      wr(8'h09, 8'h01 << i);
      idle(2);
      chk({7'h00, glob}, 8'h01, "enabled source missing");
      rd(8'h07, (8'h01 << i) | 8'h40);
      wr(8'h07, 8'h01 << i);
      idle(2);
      chk({7'h00, glob}, 8'h00, "global stuck after clear");
    end
    tend("second bank");
    // Hardware set beside a software clear keeps the flag
    @(posedge i_clk);
    i_addr <= 8'h07;
    i_wdata <= 8'h01;
    i_wr <= 1'b1;
    tmr <= 5'h01;
    @(posedge i_clk);
    i_wr <= 1'b0;
    tmr <= 5'h00;
    rd(8'h07, 8'h01);
    wr(8'h07, 8'h01);
    rd(8'h07, 8'h00);
    tend("set wins");
    // First bank sources; fault flag comes from the error register
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h08, 8'h7F ^ (8'h01 << i));
      if (i == 1)
        evt(9'h000, 5'h00, 8'h02, 8'h00);
      else
        evt(9'(9'h001 << i), 5'h00, 8'h00, 8'h00);
      idle(3);
      chk({7'h00, glob}, 8'h00, "masked first source raised global");
      rd(8'h06, 8'h01 << i);
      wr(8'h08, 8'h01 << i);
      idle(2);
      chk({7'h00, glob}, 8'h01, "enabled first source missing");
      wr(8'h06, 8'h01 << i);
      idle(2);
      chk({7'h00, glob}, 8'h00, "global stuck after first clear");
    end
    evt(9'h080, 5'h00, 8'h00, 8'hFF);
    rd(8'h06, 8'h10);
    rd(8'h0A, 8'h00);
    wr(8'h06, 8'h10);
    tend("first bank");
    // Error bits outside the fault list leave the fault flag alone
    evt(9'h000, 5'h00, 8'h94, 8'h00);
    rd(8'h0A, 8'h94);
    rd(8'h06, 8'h00);
    evt(9'h000, 5'h00, 8'h69, 8'h00);
    rd(8'h0A, 8'hFD);
    rd(8'h06, 8'h02);
    wr(8'h06, 8'h02);
    evt(9'h000, 5'h00, 8'h00, 8'hFF);
    tend("error register");
    // Pin polarity, drive mode and pin enable over all combinations
    for (int k = 0; k < 16; k++)
    begin
      wr(8'h07, k[3] ? 8'h81 : 8'h01);
      wr(8'h08, {k[2], 7'h00});
      wr(8'h09, {k[1], k[0], 6'h01});
      idle(3);
      lvl = (k[3] & k[0]) ^ k[2];
      chk({7'h00, pin_level}, {7'h00, lvl}, "pin level");
      chk({7'h00, pin_out}, {7'h00, k[1] ? lvl : 1'b0}, "pin output value");
      chk({7'h00, pin_oe_n}, {7'h00, k[1] ? 1'b0 : lvl}, "pin drive mode");
    end
    tend("pin");
    // Reset in mid-run clears flags, enables and global
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h07, 8'h00);
    rd(8'h09, 8'h00);
    chk({7'h00, glob}, 8'h00, "global after mid-run reset");
    tend("mid-run reset");
    print_verdict();
  end
endmodule
`default_nettype wire
